// File: fts_spectrum.sv
// Purpose: Gathers a time record and transforms it into amplitude/phase lines.
// Assumes: Samples arrive no faster than one per clock, each as a pulse.
// Notes: Lines leave through a small buffer that the receiver may stall.
`timescale 1ns/1ns
`default_nettype none
`include "fts_params.svh"
module fts_spectrum #(
    parameter int N  = `FTS_REC_LEN,
    parameter int SW = `FTS_SMP_W,
    parameter int PW = `FTS_PH_W
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_slide_en,
    input  wire logic                   i_smp_valid,
    input  wire logic signed [SW-1:0]   i_smp_data,
    output logic                        o_rec_full,
    output logic                        o_busy,
    output logic                        o_line_valid,
    input  wire logic                   i_line_ready,
    output logic [$clog2(N)-2:0]        o_line_index,
    output logic                        o_line_last,
    output logic signed [SW+3:0]        o_line_amp,
    output logic [PW-1:0]               o_line_phase
);
    import fts_pkg::*;

    localparam int LB = $clog2(N);
    localparam int XW = SW + 4;
    localparam int MW = SW + 18 + LB;
    localparam int TW = LB;
    localparam int OW = TW + XW + PW;

    // The record length is a build-time constant. see R11
    logic signed [SW-1:0] rec_mem  [N];
    logic signed [SW-1:0] work_mem [N];

    fts_state_t           state_q;
    logic [LB-1:0]        wr_q;
    logic [LB-1:0]        base_q;
    logic [LB-1:0]        n_q;
    logic [LB-2:0]        k_q;
    logic [LB:0]          fill_q;
    logic [LB:0]          new_q;
    logic signed [MW-1:0] acc_re_q;
    logic signed [MW-1:0] acc_im_q;

    logic                 start_xfm;
    logic                 last_bin;
    logic [LB-1:0]        pidx;
    logic signed [16:0]   cos_v;
    logic signed [16:0]   sin_v;
    logic signed [SW-1:0] smp_v;
    logic signed [SW+16:0] pr_re;
    logic signed [SW+16:0] pr_im;
    logic signed [MW-1:0] sc_re;
    logic signed [MW-1:0] sc_im;
    logic                 pol_idle;
    logic                 pol_start;
    logic                 pol_valid;
    logic                 buf_in_ready;
    logic signed [XW-1:0] pol_amp;
    logic [PW-1:0]        pol_phase;
    logic [TW-1:0]        pol_tag;
    logic [OW-1:0]        buf_out;

    // Sine of a turn fraction p/N in Q15, by a refined parabola.
    function automatic logic signed [16:0] tw_sin(input logic [LB-1:0] p);
        logic [31:0]        x;
        logic [31:0]        y;
        logic [31:0]        t;
        logic [31:0]        c;
        logic signed [16:0] s;
        x = 32'(p[LB-2:0]) << (16 - LB);
        y = (x * (`FTS_TW_ONE - x)) >> (`FTS_TW_FRAC - 2);
        t = (y * y) >> `FTS_TW_FRAC;
        c = ((y - t) * `FTS_TW_REFINE) >> `FTS_TW_FRAC;
        s = 17'(y - c);
        tw_sin = p[LB-1] ? -s : s;
    endfunction

    assign o_rec_full = (fill_q == (LB + 1)'(N));
    assign o_busy     = (state_q != S_IDLE);
    assign last_bin   = (k_q == (LB - 1)'(N / 2 - 1));

    // In slide mode an idle engine starts a fresh record once at least one new sample has come. see R5
    assign start_xfm = (state_q == S_IDLE) && o_rec_full // see R4
        && (i_slide_en ? (new_q != '0) : (new_q == (LB + 1)'(N)));

    // Line k advances its twiddle by k steps per sample. see R8
    assign pidx  = LB'(k_q * n_q);
    assign sin_v = tw_sin(pidx);
    assign cos_v = tw_sin(pidx + LB'(N / 4));
    assign smp_v = work_mem[n_q];
    assign pr_re = smp_v * cos_v;
    assign pr_im = smp_v * sin_v;

    // Dividing by N turns the zero line sum into the mean. see R9
    assign sc_re = acc_re_q >>> (`FTS_TW_FRAC + LB);
    assign sc_im = acc_im_q >>> (`FTS_TW_FRAC + LB);

    assign pol_start = (state_q == S_HAND) && pol_idle;

    // Incoming samples always land in the ring, oldest overwritten. see R1
    always_ff @(posedge i_sys_clk) begin
        if (i_smp_valid) begin // see R13
            rec_mem[wr_q] <= i_smp_data;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q   <= '0;
            fill_q <= '0; // see R14
        end else if (i_smp_valid) begin
            wr_q <= wr_q + 1'b1;
            if (!o_rec_full) begin
                fill_q <= fill_q + 1'b1;
            end
        end
    end

    // Counts samples that arrived since the last snapshot.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            new_q <= '0;
        end else if (start_xfm) begin
            new_q <= '0;
        end else if (i_smp_valid && new_q != (LB + 1)'(N)) begin // see R12
            new_q <= new_q + 1'b1;
        end
    end

    // The snapshot copy stays ahead of any sample written meanwhile.
    always_ff @(posedge i_sys_clk) begin
        if (state_q == S_COPY) begin
            work_mem[n_q] <= rec_mem[base_q + n_q];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            base_q  <= '0;
            n_q     <= '0;
            k_q     <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_xfm) begin
                        base_q  <= i_smp_valid ? wr_q + 1'b1 : wr_q;
                        n_q     <= '0;
                        k_q     <= '0;
                        state_q <= S_COPY;
                    end
                end
                S_COPY: begin
                    n_q <= n_q + 1'b1;
                    if (n_q == LB'(N - 1)) begin
                        state_q <= S_MAC;
                    end
                end
                S_MAC: begin // see R3
                    n_q <= n_q + 1'b1;
                    if (n_q == LB'(N - 1)) begin
                        state_q <= S_HAND;
                    end
                end
                S_HAND: begin
                    if (pol_idle) begin // see R6
                        if (last_bin) begin
                            state_q <= S_IDLE;
                        end else begin
                            k_q     <= k_q + 1'b1; // see R10
                            state_q <= S_MAC;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_re_q <= '0;
            acc_im_q <= '0;
        end else if (state_q == S_MAC) begin
            acc_re_q <= acc_re_q + MW'(pr_re);
            acc_im_q <= acc_im_q - MW'(pr_im);
        end else if (state_q != S_HAND || pol_idle) begin
            acc_re_q <= '0;
            acc_im_q <= '0;
        end
    end

    fts_polar #(
        .XW (XW),
        .PW (PW),
        .TW (TW)
    ) u_polar (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_start   (pol_start),
        .i_dc      (k_q == '0),
        .i_x       (XW'(sc_re)),
        .i_y       (XW'(sc_im)),
        .i_tag     ({k_q, last_bin}),
        .o_idle    (pol_idle),
        .o_valid   (pol_valid),
        .i_ready   (buf_in_ready),
        .o_amp     (pol_amp),
        .o_phase   (pol_phase),
        .o_tag     (pol_tag)
    );

    fts_buf #(
        .W     (OW),
        .DEPTH (`FTS_BUF_DEPTH)
    ) u_buf (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_valid    (pol_valid),
        .o_in_ready (buf_in_ready),
        .i_data     ({pol_tag, pol_amp, pol_phase}),
        .o_valid    (o_line_valid),
        .i_ready    (i_line_ready),
        .o_data     (buf_out)
    );

    // Each line leaves with its amplitude and its phase. see R7
    assign o_line_index = buf_out[OW-1 -: (LB - 1)];
    assign o_line_last  = buf_out[OW-LB];
    assign o_line_amp   = buf_out[PW+XW-1 : PW];
    assign o_line_phase = buf_out[PW-1:0];

    pow2_len_a: assert property (@(posedge i_sys_clk) (N & (N - 1)) == 0) // see R2
        else $error("Record length is not a power of two.");

    no_early_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R4
        state_q == S_COPY |-> o_rec_full)
        else $error("Transform started before the record filled.");

    fill_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R14
        i_smp_valid && !o_rec_full |=> fill_q == $past(fill_q) + 1'b1)
        else $error("Fill count missed a sample.");

    ring_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R5
        i_smp_valid |=> rec_mem[$past(wr_q)] == $past(i_smp_data) && wr_q == $past(wr_q) + 1'b1)
        else $error("New sample not appended to the record.");

    whole_rec_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R3
        state_q == S_MAC && n_q != LB'(N - 1) |=> state_q == S_MAC)
        else $error("Line left the sum before all samples.");

    bin_count_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R6
        state_q == S_HAND && pol_idle && last_bin |=> state_q == S_IDLE)
        else $error("Wrong number of lines per record.");

    line_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R10
        state_q == S_HAND && pol_idle && !last_bin |=> k_q == $past(k_q) + 1'b1)
        else $error("Lines not equally spaced.");

    low_line_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R8
        state_q == S_MAC && n_q == LB'(1) |-> pidx == LB'(k_q))
        else $error("Twiddle step does not match the line number.");
endmodule // fts_spectrum
`default_nettype wire

// File: fts_params.svh
// Purpose: Constants for the time record spectrum engine.
// Assumes: One 100 MHz clock, asynchronous active high reset.
// Notes: Offsets, widths and timing counts live here as macros.
//
// Notes on behaviour
// R1: Record is consecutive equally spaced samples, no gaps.
// R2: Record length is a power of two.
// R3: Whole record transformed; every sample feeds every line.
// R4: No valid spectrum before the first full record.
// R5: When full, oldest sample drops, newest appends.
// R6: Half as many lines as record samples.
// R7: Each line carries amplitude and phase.
// R8: Lowest nonzero line is one over record time.
// R9: Zero frequency line is the record mean.
// R10: Adjacent lines spaced by one over record time.
// R11: Record length fixed at build time.
// R12: Span changes only through the sample rate.
// R13: Source gives one-cycle valid per sample strobe.
// R14: Reset clears the fill count.
`ifndef FTS_PARAMS_SVH
`define FTS_PARAMS_SVH

`define FTS_REC_LEN     1024
`define FTS_SMP_W       16
`define FTS_PH_W        16
`define FTS_TW_FRAC     15
`define FTS_TW_ONE      32'h0000_8000
`define FTS_TW_REFINE   32'h0000_1CCD
`define FTS_HALF_TURN   16'h8000
`define FTS_CORDIC_ITER 12
`define FTS_BUF_DEPTH   2

`endif

// File: fts_pkg.sv
// Purpose: Types shared by the spectrum engine.
// Assumes: Nothing beyond the constants header.
// Notes: Sequencer states only.
package fts_pkg;
    typedef enum logic [1:0] {
        S_IDLE,
        S_COPY,
        S_MAC,
        S_HAND
    } fts_state_t;
endpackage

// File: fts_buf.sv
// Purpose: Small FIFO between the line producer and the line consumer.
// Assumes: Depth of at least two.
// Notes: A full buffer drops its input ready, which stalls the producer.
`timescale 1ns/1ns
`default_nettype none
`include "fts_params.svh"
module fts_buf #(
    parameter int W     = 8,
    parameter int DEPTH = `FTS_BUF_DEPTH
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic         i_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AB = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AB-1:0] rd_q;
    logic [AB-1:0] wr_q;
    logic [AB:0]   cnt_q;
    logic          push;
    logic          pop;

    function automatic logic [AB-1:0] step(input logic [AB-1:0] p);
        step = (p == AB'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign o_in_ready = (cnt_q != (AB + 1)'(DEPTH));
    assign o_valid    = (cnt_q != '0);
    assign o_data     = mem[rd_q];
    assign push       = i_valid && o_in_ready;
    assign pop        = o_valid && i_ready;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= step(wr_q);
            end
            if (pop) begin
                rd_q <= step(rd_q);
            end
            cnt_q <= cnt_q + (AB + 1)'(push) - (AB + 1)'(pop);
        end
    end

    stall_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_valid && !i_ready |=> o_valid && $stable(o_data))
        else $error("Buffered line changed while stalled.");
endmodule // fts_buf
`default_nettype wire

// File: fts_polar.sv
// Purpose: Turns a line's real and imaginary parts into amplitude and phase.
// Assumes: Inputs leave two bits of headroom for the rotation gain.
// Notes: Amplitude of every line but the zero line carries the rotation gain of about 1.647.
`timescale 1ns/1ns
`default_nettype none
`include "fts_params.svh"
module fts_polar #(
    parameter int XW = 20,
    parameter int PW = `FTS_PH_W,
    parameter int TW = 10
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_start,
    input  wire logic                 i_dc,
    input  wire logic signed [XW-1:0] i_x,
    input  wire logic signed [XW-1:0] i_y,
    input  wire logic [TW-1:0]        i_tag,
    output logic                      o_idle,
    output logic                      o_valid,
    input  wire logic                 i_ready,
    output logic signed [XW-1:0]      o_amp,
    output logic [PW-1:0]             o_phase,
    output logic [TW-1:0]             o_tag
);
    logic signed [XW-1:0] x_q;
    logic signed [XW-1:0] y_q;
    logic [PW-1:0]        a_q;
    logic [3:0]           it_q;
    logic                 busy_q;
    logic                 vld_q;
    logic [TW-1:0]        tag_q;

    function automatic logic [PW-1:0] atan_step(input logic [3:0] i);
        case (i)
            4'h0:    atan_step = PW'(16'h2000);
            4'h1:    atan_step = PW'(16'h12E4);
            4'h2:    atan_step = PW'(16'h09FB);
            4'h3:    atan_step = PW'(16'h0511);
            4'h4:    atan_step = PW'(16'h028B);
            4'h5:    atan_step = PW'(16'h0146);
            4'h6:    atan_step = PW'(16'h00A3);
            4'h7:    atan_step = PW'(16'h0051);
            4'h8:    atan_step = PW'(16'h0029);
            4'h9:    atan_step = PW'(16'h0014);
            4'hA:    atan_step = PW'(16'h000A);
            4'hB:    atan_step = PW'(16'h0005);
            default: atan_step = '0;
        endcase
    endfunction

    // Shifts toward zero so a small negative value cannot stick at minus one.
    function automatic logic signed [XW-1:0] shr_tz(input logic signed [XW-1:0] v,
                                                    input logic [3:0] s);
        shr_tz = (v < 0) ? -((-v) >>> s) : (v >>> s);
    endfunction

    assign o_idle  = !busy_q && !vld_q;
    assign o_valid = vld_q;
    assign o_amp   = x_q;
    assign o_phase = a_q;
    assign o_tag   = tag_q;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            x_q    <= '0;
            y_q    <= '0;
            a_q    <= '0;
            it_q   <= '0;
            busy_q <= 1'b0;
            vld_q  <= 1'b0;
            tag_q  <= '0;
        end else if (i_start) begin
            busy_q <= !i_dc;
            vld_q  <= i_dc;
            tag_q  <= i_tag;
            it_q   <= '0;
            if (i_dc) begin // see R9
                x_q <= i_x;
                y_q <= '0;
                a_q <= '0;
            end else if (i_x < 0) begin
                x_q <= -i_x;
                y_q <= -i_y;
                a_q <= PW'(`FTS_HALF_TURN);
            end else begin
                x_q <= i_x;
                y_q <= i_y;
                a_q <= '0;
            end
        end else if (busy_q) begin // see R7
            if (y_q >= 0) begin
                x_q <= x_q + shr_tz(y_q, it_q);
                y_q <= y_q - shr_tz(x_q, it_q);
                a_q <= a_q + atan_step(it_q);
            end else begin
                x_q <= x_q - shr_tz(y_q, it_q);
                y_q <= y_q + shr_tz(x_q, it_q);
                a_q <= a_q - atan_step(it_q);
            end
            it_q <= it_q + 4'h1;
            if (it_q == 4'(`FTS_CORDIC_ITER - 1)) begin
                busy_q <= 1'b0;
                vld_q  <= 1'b1;
            end
        end else if (vld_q && i_ready) begin
            vld_q <= 1'b0;
        end
    end

    dc_mean_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R9
        i_start && i_dc |=> o_valid && o_phase == '0 && o_amp == $past(i_x))
        else $error("Zero line did not pass the mean straight through.");

    polar_lat_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see R7
        i_start && !i_dc |=> !o_valid [*8] ##1 !o_valid [*4] ##1 o_valid)
        else $error("Amplitude and phase not ready after the rotation.");
endmodule // fts_polar
`default_nettype wire

// File: fts_smp_src.sv
// Purpose: Sample source model that feeds the spectrum engine.
// Assumes: One clock; sample values come from a table given by the bench.
// Notes: Between strobes the data line shows the inverse of the last sample.
`timescale 1ns/1ns
`default_nettype none
module fts_smp_src (
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst,
    input  wire logic               i_go,
    input  wire logic [3:0]         i_first,
    input  wire logic [7:0]         i_count,
    input  wire logic [7:0]         i_gap,
    input  wire logic signed [15:0] i_table [0:15],
    output logic                    o_smp_valid,
    output logic signed [15:0]      o_smp_data,
    output logic                    o_done
);
    logic [7:0] left_q;
    logic [3:0] pos_q;
    logic [7:0] wait_q;

    assign o_done = (left_q == 8'h00) && !o_smp_valid && !i_go;

    // One pulse per strobe, spaced by the gap that sets the sample rate.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            left_q      <= 8'h00;
            pos_q       <= 4'h0;
            wait_q      <= 8'h00;
            o_smp_valid <= 1'b0;
            o_smp_data  <= 16'h0000;
        end else if (i_go) begin
            left_q      <= i_count;
            pos_q       <= i_first;
            wait_q      <= 8'h00;
            o_smp_valid <= 1'b0;
        end else if (left_q != 8'h00 && wait_q == 8'h00) begin
            o_smp_valid <= 1'b1;
            o_smp_data  <= i_table[pos_q];
            pos_q       <= pos_q + 4'h1;
            left_q      <= left_q - 8'h01;
            wait_q      <= i_gap;
        end else begin
            o_smp_valid <= 1'b0;
            if (o_smp_valid) begin
                o_smp_data <= ~o_smp_data;
            end
            if (wait_q != 8'h00) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end
endmodule // fts_smp_src
`default_nettype wire

// File: test_fts_spectrum.sv
// Purpose: Self-checking bench for the spectrum engine.
// Assumes: Record length 16; expected lines come from a reference transform.
// Notes: The receiver stalls in some scenarios to exercise the line buffer.
`timescale 1ns/1ns
`default_nettype none
module test_fts_spectrum;
    localparam int  N     = 16;
    localparam int  L     = N / 2;
    localparam int  LIMIT = 20000;
    localparam real PI    = 3.14159265358979;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic slide_en = 1'b0;
    logic line_ready = 1'b0;
    logic smp_valid, rec_full, busy, line_valid, line_last, src_done;
    logic signed [15:0] smp_data;
    logic [2:0] line_index;
    logic signed [19:0] line_amp;
    logic [15:0] line_phase;
    logic go = 1'b0;
    logic [3:0] first = 4'h0;
    logic [7:0] count = 8'h00;
    logic [7:0] gap = 8'h00;
    logic signed [15:0] tbl [0:15];
    logic signed [19:0] amp_a [0:L-1];
    logic [15:0] ph_a [0:L-1];
    logic [2:0] idx_a [0:L-1];
    logic last_a [0:L-1];
    int hist[$];
    int n_lines = 0;
    int cyc = 0;
    int err_total = 0;
    int total_checks = 0;
    bit stall = 1'b0;

    fts_spectrum #(.N(N)) dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_slide_en(slide_en),
        .i_smp_valid(smp_valid), .i_smp_data(smp_data), .o_rec_full(rec_full),
        .o_busy(busy), .o_line_valid(line_valid), .i_line_ready(line_ready),
        .o_line_index(line_index), .o_line_last(line_last),
        .o_line_amp(line_amp), .o_line_phase(line_phase));
    fts_smp_src src (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_go(go), .i_first(first),
        .i_count(count), .i_gap(gap), .i_table(tbl), .o_smp_valid(smp_valid),
        .o_smp_data(smp_data), .o_done(src_done));

    always #5 sys_clk = ~sys_clk;

    // Receiver: takes lines on valid and ready, stalls when asked.
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        line_ready <= stall ? (cyc % 3 != 0) : 1'b1;
        if (line_valid === 1'b1 && line_ready === 1'b1) begin
            if (n_lines < L) begin
                amp_a[n_lines] = line_amp;
                ph_a[n_lines]  = line_phase;
                idx_a[n_lines] = line_index;
                last_a[n_lines] = line_last;
            end
            n_lines = n_lines + 1;
        end
        if (cyc == LIMIT) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_eq(input logic [19:0] got, input logic [19:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic check_near(input logic [19:0] got, input real exp, input real tol,
                              input string what);
        real d;
        total_checks++;
        d = $itor($signed(got)) - exp;
        if (^got === 1'bx || d > tol || d < -tol) begin
            err_total++;
            $display("wrong value at %0t: %s got %0d want %0f", $time, what, $signed(got), exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic make_tone(input int k, input real a, input real ph);
        for (int n = 0; n < 16; n++) begin
            tbl[n] = 16'($rtoi($floor(a * $cos(2.0 * PI * k * n / N + ph) + 0.5)));
        end
    endtask

    task automatic start_src(input int f, input int c, input int g);
        @(posedge sys_clk);
        go    <= 1'b1;
        first <= 4'(f);
        count <= 8'(c);
        gap   <= 8'(g);
        @(posedge sys_clk);
        go <= 1'b0;
    endtask

    task automatic feed(input int f, input int c, input int g);
        int i;
        start_src(f, c, g);
        for (i = 0; i < 2000 && src_done !== 1'b1; i++) tick(1);
        for (i = 0; i < c; i++) begin
            hist.push_back(int'(tbl[(f + i) % 16]));
            if (hist.size() > N) void'(hist.pop_front());
        end
        tick(2);
    endtask

    // Waits for one record's lines and compares them with a reference transform.
    task automatic check_spectrum();
        real re, im, mag, pe;
        int s, i;
        logic [15:0] dd;
        for (i = 0; i < 3000 && n_lines < L; i++) tick(1);
        tick(60);
        check_eq(20'(n_lines), 20'(L), "line count");
        s = 0;
        for (int n = 0; n < N; n++) s += hist[hist.size() - N + n];
        for (int k = 0; k < L; k++) begin
            check_eq(20'(idx_a[k]), 20'(k), "line index");
            check_eq(20'(last_a[k]), 20'(k == L - 1), "last flag");
            if (k == 0) begin
                check_eq(amp_a[0], 20'(s >>> $clog2(N)), "mean line");
                check_eq(20'(ph_a[0]), 20'h00000, "mean phase");
            end else begin
                re = 0.0;
                im = 0.0;
                for (int n = 0; n < N; n++) begin
                    re += hist[hist.size() - N + n] * $cos(2.0 * PI * k * n / N);
                    im -= hist[hist.size() - N + n] * $sin(2.0 * PI * k * n / N);
                end
                mag = $sqrt(re * re + im * im) / N * 1.647;
                check_near(amp_a[k], mag, mag * 0.03 + 6.0, "amplitude");
                if (mag > 40.0) begin
                    pe = $atan2(im, re) / (2.0 * PI) * 65536.0;
                    dd = ph_a[k] - 16'($rtoi($floor(pe + 65536.5)));
                    check_near({{4{dd[15]}}, dd}, 0.0, 400.0, "phase");
                end
            end
        end
    endtask

    task automatic t_reset();
        check_eq(20'(rec_full), 20'h00000, "full after reset");
        check_eq(20'(busy), 20'h00000, "busy after reset");
        check_eq(20'(line_valid), 20'h00000, "valid after reset");
    endtask

    task automatic t_block_tone();
        make_tone(1, 1000.0, 0.0);
        stall = 1'b1;
        feed(0, 15, 0);
        tick(40);
        check_eq(20'(rec_full), 20'h00000, "full too early");
        check_eq(20'(n_lines), 20'h00000, "lines too early");
        feed(15, 1, 0);
        check_eq(20'(rec_full), 20'h00001, "full after record");
        check_spectrum();
    endtask

    task automatic t_impulse_gap();
        for (int n = 0; n < 16; n++) tbl[n] = 16'h0000;
        tbl[5] = -16'sd1605;
        stall = 1'b0;
        n_lines = 0;
        feed(0, 16, 3);
        check_spectrum();
    endtask

    task automatic t_slide();
        slide_en <= 1'b1;
        n_lines = 0;
        feed(0, 1, 0);
        check_spectrum();
    endtask

    task automatic t_mid_reset();
        make_tone(3, 900.0, -PI / 2.0);
        start_src(0, 16, 2);
        tick(12);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        hist.delete();
        tick(2);
        t_reset();
        n_lines = 0;
        stall = 1'b1;
        feed(0, 15, 1);
        tick(40);
        check_eq(20'(n_lines), 20'h00000, "lines before refill");
        feed(15, 1, 0);
        check_eq(20'(rec_full), 20'h00001, "full after refill");
        check_spectrum();
    endtask

    initial begin
        for (int n = 0; n < 16; n++) tbl[n] = 16'h0000;
        tick(10);
        rst <= 1'b0;
        tick(2);
        t_reset();
        t_block_tone();
        t_impulse_gap();
        t_slide();
        t_mid_reset();
        summarize();
    end
endmodule // test_fts_spectrum
`default_nettype wire
